// File: core/glpe_regs.svh
// register offsets, field positions, reset values and time-base counts
// of the pin-four pwm encoder; included by the package users.
`ifndef GLPE_REGS_SVH
`define GLPE_REGS_SVH

// register indices; the bus byte address is four times the index
`define GLPE_LL_IDX 8'h57
`define GLPE_LH_IDX 8'h58
`define GLPE_STAT_IDX 8'h60

// field positions
`define GLPE_TB_MSB 15
`define GLPE_TB_LSB 14
`define GLPE_HC_MSB 13
`define GLPE_HC_LSB 7
`define GLPE_LC_MSB 6
`define GLPE_LC_LSB 0

// reset values
`define GLPE_LL_RST 16'h007f
`define GLPE_LH_RST 16'h3f80

// time-base lengths in master-clock cycles
`define GLPE_TB0_CYC 11'd16
`define GLPE_TB1_CYC 11'd64
`define GLPE_TB2_CYC 11'd256
`define GLPE_TB3_CYC 11'd1024

// axi response codes
`define GLPE_RESP_OKAY 2'h0
`define GLPE_RESP_SLVERR 2'h2

`endif

// File: core/glpe_pkg.sv
// types shared by the pin-four pwm encoder files.
// assumes the constants header is on the include path.
`default_nettype none
package glpe_pkg;

	typedef enum logic [1:0] {
		GLPE_TB_16 = 2'b00,
		GLPE_TB_64 = 2'b01,
		GLPE_TB_256 = 2'b10,
		GLPE_TB_1024 = 2'b11
	} glpe_tb_t;

	typedef struct packed {
		logic [6:0] hc;
		logic [6:0] lc;
	} glpe_pair_t;

	typedef struct packed {
		glpe_tb_t tb;
		glpe_pair_t pair;
	} glpe_llcfg_t;

	typedef enum logic [0:0] {
		GLPE_PH_HIGH = 1'b0,
		GLPE_PH_LOW = 1'b1
	} glpe_phase_t;

endpackage
`default_nettype wire

// File: core/glpe_tick.sv
// time-base divider: one-cycle tick every selected number of clocks.
// assumes a single clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "glpe_regs.svh"

module glpe_tick (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire glpe_pkg::glpe_tb_t sel_i,
	output logic tick_o
);

	logic [9:0] cnt;
	logic [9:0] last;

	// 1024 periods: last count is 1023, held in ten bits
	always_comb begin
		case (sel_i)
			glpe_pkg::GLPE_TB_16: last = 10'(`GLPE_TB0_CYC - 11'd1);
			glpe_pkg::GLPE_TB_64: last = 10'(`GLPE_TB1_CYC - 11'd1);
			glpe_pkg::GLPE_TB_256: last = 10'(`GLPE_TB2_CYC - 11'd1);
			glpe_pkg::GLPE_TB_1024: last = 10'(`GLPE_TB3_CYC - 11'd1);
			default: last = 10'(`GLPE_TB0_CYC - 11'd1);
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cnt <= 10'h000;
			tick_o <= 1'b0;
		end else if (cnt >= last) begin
			cnt <= 10'h000;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 10'h001;
			tick_o <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// File: core/glpe_pwm.sv
// pin-four pwm encoder with its axi4-lite register slave.
// assumes one clock, a synchronous reset and a pin level from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
`include "glpe_regs.svh"

// Behaviour
// - a 2-bit selection gives time bases of 16, 64, 256 or 1024 clocks.
// - the selected time base paces the waveform driven on pin four.
// - one period lasts high count plus low count time-base intervals.
// - the pin stays high for the active high count of intervals.
// - the pin stays low for the active low count of intervals.
// - a low pin level selects the pair held in the low-level register.
// - a high pin level selects the pair held in the high-level register.
// - a zero high count gives a static low pin.
// - a zero low count with nonzero high count gives a static high pin.
// - both counts zero give a static low pin.
// - reset loads the low pair as 0/127 and the high pair as 127/0.
module glpe_pwm (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [11:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [11:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic pin4_output_level_i,
	output logic shared_pin_four_o
);

	// register select from a byte address
	function automatic logic [1:0] decode(input logic [11:0] addr);
		if (addr[1:0] != 2'b00)
			decode = 2'd0;
		else if (addr[11:2] == {2'b00, `GLPE_LL_IDX})
			decode = 2'd1;
		else if (addr[11:2] == {2'b00, `GLPE_LH_IDX})
			decode = 2'd2;
		else if (addr[11:2] == {2'b00, `GLPE_STAT_IDX})
			decode = 2'd3;
		else
			decode = 2'd0;
	endfunction

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		merge = old;
		if (strb[0])
			merge[7:0] = d[7:0];
		if (strb[1])
			merge[15:8] = d[15:8];
	endfunction

	glpe_pkg::glpe_llcfg_t ll_cfg;
	glpe_pkg::glpe_pair_t lh_pair;
	glpe_pkg::glpe_pair_t act;
	glpe_pkg::glpe_phase_t phase;
	glpe_pkg::glpe_phase_t next_phase;
	logic [6:0] cnt;
	logic [6:0] next_cnt;
	logic next_pin;
	logic tick;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [1:0] wsel;
	logic [15:0] ll_merged;
	logic [15:0] lh_merged;
	logic [31:0] rd_word;
	logic [1:0] rsel;

	// write address channel
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			awready_o <= 1'b1;
			aw_addr <= 12'h000;
		end else if (awvalid_i && awready_o) begin
			awready_o <= 1'b0;
			aw_addr <= awaddr_i;
		end else if (bvalid_o && bready_i) begin
			awready_o <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wready_o <= 1'b1;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (wvalid_i && wready_o) begin
			wready_o <= 1'b0;
			w_data <= wdata_i;
			w_strb <= wstrb_i;
		end else if (bvalid_o && bready_i) begin
			wready_o <= 1'b1;
		end
	end

	// both halves held and no response pending
	assign do_write = !awready_o && !wready_o && !bvalid_o;
	assign wsel = decode(aw_addr);
	assign ll_merged = merge(ll_cfg, w_data, w_strb);
	assign lh_merged = merge({2'b00, lh_pair}, w_data, w_strb);

	// write response channel
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= `GLPE_RESP_OKAY;
		end else if (do_write) begin
			bvalid_o <= 1'b1;
			if (wsel == 2'd1 || wsel == 2'd2)
				bresp_o <= `GLPE_RESP_OKAY;
			else
				bresp_o <= `GLPE_RESP_SLVERR;
		end else if (bvalid_o && bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ll_cfg <= `GLPE_LL_RST;
			lh_pair <= 14'(`GLPE_LH_RST);
		end else if (do_write && wsel == 2'd1) begin
			ll_cfg <= ll_merged;
		end else if (do_write && wsel == 2'd2) begin
			lh_pair <= lh_merged[13:0];
		end
	end

	assign rsel = decode(araddr_i);

	// read mux; reserved bits read zero
	always_comb begin
		rd_word = 32'h00000000;
		case (rsel)
			2'd1: rd_word[15:0] = ll_cfg;
			2'd2: rd_word[13:0] = lh_pair;
			2'd3: rd_word[2:0] = {pin4_output_level_i, phase, shared_pin_four_o};
			default: rd_word = 32'h00000000;
		endcase
	end

	// read channels
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			arready_o <= 1'b1;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h00000000;
			rresp_o <= `GLPE_RESP_OKAY;
		end else if (arvalid_i && arready_o) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= rd_word;
			if (rsel == 2'd0)
				rresp_o <= `GLPE_RESP_SLVERR;
			else
				rresp_o <= `GLPE_RESP_OKAY;
		end else if (rvalid_o && rready_i) begin
			rvalid_o <= 1'b0;
			arready_o <= 1'b1;
		end
	end

	// one time base for both pairs
	glpe_tick u_tick (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.sel_i(ll_cfg.tb),
		.tick_o(tick)
	);

	// pair chosen by the pin's output value
	assign act = pin4_output_level_i ? lh_pair : ll_cfg.pair;

	// waveform sequencer: high phase then low phase, counted in ticks
	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		next_pin = 1'b0;
		if (act.hc == 7'h00) begin
			next_phase = glpe_pkg::GLPE_PH_HIGH;
			next_cnt = 7'h00;
			next_pin = 1'b0;
		end else if (act.lc == 7'h00) begin
			next_phase = glpe_pkg::GLPE_PH_HIGH;
			next_cnt = 7'h00;
			next_pin = 1'b1;
		end else begin
			case (phase)
				glpe_pkg::GLPE_PH_HIGH: begin
					if (tick) begin
						if ({1'b0, cnt} + 8'h01 >= {1'b0, act.hc}) begin
							next_phase = glpe_pkg::GLPE_PH_LOW;
							next_cnt = 7'h00;
						end else begin
							next_cnt = cnt + 7'h01;
						end
					end
				end
				glpe_pkg::GLPE_PH_LOW: begin
					if (tick) begin
						if ({1'b0, cnt} + 8'h01 >= {1'b0, act.lc}) begin
							next_phase = glpe_pkg::GLPE_PH_HIGH;
							next_cnt = 7'h00;
						end else begin
							next_cnt = cnt + 7'h01;
						end
					end
				end
				default: begin
					next_phase = glpe_pkg::GLPE_PH_HIGH;
					next_cnt = 7'h00;
				end
			endcase
			next_pin = (next_phase == glpe_pkg::GLPE_PH_HIGH);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			phase <= glpe_pkg::GLPE_PH_HIGH;
			cnt <= 7'h00;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			shared_pin_four_o <= 1'b0;
		else
			shared_pin_four_o <= next_pin;
	end

	// checks

	property p_tb16;
		@(posedge clk_i) disable iff (reset_i)
		(tick && ll_cfg.tb == glpe_pkg::GLPE_TB_16)
			|-> ##16 (tick || ll_cfg.tb != glpe_pkg::GLPE_TB_16);
	endproperty
	a_tb16: assert property (p_tb16) else $error("tick spacing not 16");

	property p_tb64;
		@(posedge clk_i) disable iff (reset_i)
		(tick && ll_cfg.tb == glpe_pkg::GLPE_TB_64)
			|=> !tick [*1] ##63 (tick || ll_cfg.tb != glpe_pkg::GLPE_TB_64);
	endproperty
	a_tb64: assert property (p_tb64) else $error("tick spacing not 64");

	property p_tb256;
		@(posedge clk_i) disable iff (reset_i)
		(tick && ll_cfg.tb == glpe_pkg::GLPE_TB_256)
			|=> !tick [*1] ##255 (tick || ll_cfg.tb != glpe_pkg::GLPE_TB_256);
	endproperty
	a_tb256: assert property (p_tb256) else $error("tick spacing not 256");

	property p_moves_on_tick;
		@(posedge clk_i) disable iff (reset_i)
		(act.hc != 7'h00 && act.lc != 7'h00 && $stable(act) && !tick)
			|=> $stable(phase);
	endproperty
	a_moves_on_tick: assert property (p_moves_on_tick) else $error("phase moved off tick");

	property p_high_len;
		@(posedge clk_i) disable iff (reset_i)
		(phase == glpe_pkg::GLPE_PH_HIGH && tick && act.hc != 7'h00 && act.lc != 7'h00
			&& cnt == act.hc - 7'h01)
			|=> (phase == glpe_pkg::GLPE_PH_LOW && cnt == 7'h00 && !shared_pin_four_o);
	endproperty
	a_high_len: assert property (p_high_len) else $error("high phase wrong length");

	property p_low_len;
		@(posedge clk_i) disable iff (reset_i)
		(phase == glpe_pkg::GLPE_PH_LOW && tick && act.hc != 7'h00 && act.lc != 7'h00
			&& cnt == act.lc - 7'h01)
			|=> (phase == glpe_pkg::GLPE_PH_HIGH && cnt == 7'h00 && shared_pin_four_o);
	endproperty
	a_low_len: assert property (p_low_len) else $error("low phase wrong length");

	property p_static_low;
		@(posedge clk_i) disable iff (reset_i)
		(act.hc == 7'h00 && act.lc != 7'h00) |=> !shared_pin_four_o;
	endproperty
	a_static_low: assert property (p_static_low) else $error("zero high count not low");

	property p_static_high;
		@(posedge clk_i) disable iff (reset_i)
		(act.lc == 7'h00 && act.hc != 7'h00) |=> shared_pin_four_o;
	endproperty
	a_static_high: assert property (p_static_high) else $error("zero low count not high");

	property p_both_zero;
		@(posedge clk_i) disable iff (reset_i)
		(act == 14'h0000) [*2] |=> !shared_pin_four_o;
	endproperty
	a_both_zero: assert property (p_both_zero) else $error("both zero not low");

	property p_lh_pair_used;
		@(posedge clk_i) disable iff (reset_i)
		(pin4_output_level_i && lh_pair.hc == 7'h00) |=> !shared_pin_four_o;
	endproperty
	a_lh_pair_used: assert property (p_lh_pair_used) else $error("high pair ignored");

	property p_ll_pair_used;
		@(posedge clk_i) disable iff (reset_i)
		(!pin4_output_level_i && ll_cfg.pair.hc == 7'h00) |=> !shared_pin_four_o;
	endproperty
	a_ll_pair_used: assert property (p_ll_pair_used) else $error("low pair ignored");

	property p_reset_vals;
		@(posedge clk_i)
		reset_i |=> (ll_cfg == `GLPE_LL_RST && lh_pair == 14'(`GLPE_LH_RST));
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_lh_reserved;
		@(posedge clk_i) disable iff (reset_i)
		(arvalid_i && arready_o && rsel == 2'd2) |=> (rvalid_o && rdata_o[31:14] == 18'h00000);
	endproperty
	a_lh_reserved: assert property (p_lh_reserved) else $error("reserved bits nonzero");

endmodule
`default_nettype wire

// File: dv/glpe_pin_monitor.sv
// pin-side model: samples the pwm pin and measures phase lengths in clocks.
// assumes the pin is driven from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module glpe_pin_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic pin_i,
	output logic [15:0] high_len_o,
	output logic [15:0] low_len_o,
	output logic [15:0] edges_o
);
	logic prev;
	logic [15:0] cnt;

	// a phase length is closed at each change of the pin
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prev <= 1'b0;
			cnt <= 16'h0000;
			high_len_o <= 16'h0000;
			low_len_o <= 16'h0000;
			edges_o <= 16'h0000;
		end else if (pin_i !== prev) begin
			if (prev)
				high_len_o <= cnt;
			else
				low_len_o <= cnt;
			cnt <= 16'h0001;
			edges_o <= edges_o + 16'h0001;
			prev <= pin_i;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// File: dv/glpe_pwm_tb_top.sv
// testbench of the pin-four pwm encoder: axi4-lite tasks and phase checks.
// assumes the constants header on the include path and the pin monitor model.
`timescale 1ns/100ps
`default_nettype none
`include "glpe_regs.svh"

module glpe_pwm_tb_top;
	logic clk_i, reset_i, lvl, pin;
	logic awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
	logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	logic [11:0] awaddr_i, araddr_i;
	logic [31:0] wdata_i, rdata_o, rd;
	logic [3:0] wstrb_i;
	logic [1:0] bresp_o, rresp_o, resp;
	logic [15:0] hlen, llen, edges;
	int num_errors = 0;
	int checks_done = 0;
	int tb_len[4] = '{16, 64, 256, 1024};
	localparam logic [11:0] LL_ADDR = 12'({`GLPE_LL_IDX, 2'b00});
	localparam logic [11:0] LH_ADDR = 12'({`GLPE_LH_IDX, 2'b00});
	localparam logic [11:0] ST_ADDR = 12'({`GLPE_STAT_IDX, 2'b00});

	glpe_pwm dut (.clk_i(clk_i), .reset_i(reset_i), .awaddr_i(awaddr_i),
		.awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
		.wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
		.bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
		.araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
		.rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
		.pin4_output_level_i(lvl), .shared_pin_four_o(pin));
	glpe_pin_monitor mon (.clk_i(clk_i), .reset_i(reset_i), .pin_i(pin),
		.high_len_o(hlen), .low_len_o(llen), .edges_o(edges));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		int n;
		@(posedge clk_i);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		r = 2'h3;
		awaddr_i <= a;
		awvalid_i <= 1'b1;
		wdata_i <= d;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (!aw_ok && awready_o === 1'b1) begin
				aw_ok = 1'b1;
				awvalid_i <= 1'b0;
			end
			if (!w_ok && wready_o === 1'b1) begin
				w_ok = 1'b1;
				wvalid_i <= 1'b0;
			end
			if (bvalid_o === 1'b1) begin
				r = bresp_o;
				bready_i <= 1'b0;
				break;
			end
		end
		if (n == 200) begin
			num_errors++;
			$display("mismatch at %0t: write got no answer", $time);
		end
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_ok;
		int n;
		@(posedge clk_i);
		ar_ok = 1'b0;
		r = 2'h3;
		d = 32'hdeadbeef;
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_i);
			if (!ar_ok && arready_o === 1'b1) begin
				ar_ok = 1'b1;
				arvalid_i <= 1'b0;
			end
			if (rvalid_o === 1'b1) begin
				d = rdata_o;
				r = rresp_o;
				rready_i <= 1'b0;
				break;
			end
		end
		if (n == 200) begin
			num_errors++;
			$display("mismatch at %0t: read got no answer", $time);
		end
	endtask

	// waits for four pin changes so the last high and low phases are whole
	task automatic pair_check(input int hc, input int lc, input int t);
		logic [15:0] target;
		int n;
		target = edges + 16'd4;
		for (n = 0; n < 12000 && edges !== target; n++)
			@(posedge clk_i);
		check(32'(edges), 32'(target));
		check(32'(hlen), 32'(hc * t));
		check(32'(llen), 32'(lc * t));
	endtask

	task automatic stat_check(input logic exp);
		logic [15:0] e0;
		repeat (4) @(posedge clk_i);
		e0 = edges;
		repeat (100) @(posedge clk_i);
		check(32'(edges - e0), 32'h0);
		check(32'(pin), 32'(exp));
	endtask

	initial begin
		repeat (60000) @(posedge clk_i);
		num_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		reset_i <= 1'b1;
		lvl <= 1'b0;
		awaddr_i <= 12'h000;
		araddr_i <= 12'h000;
		awvalid_i <= 1'b0;
		wvalid_i <= 1'b0;
		arvalid_i <= 1'b0;
		bready_i <= 1'b0;
		rready_i <= 1'b0;
		wdata_i <= 32'h0;
		wstrb_i <= 4'hf;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;

		axi_rd(LL_ADDR, rd, resp);
		check(rd, 32'h0000007f);
		axi_rd(LH_ADDR, rd, resp);
		check(rd, 32'h00003f80);
		stat_check(1'b0);
		lvl <= 1'b1;
		stat_check(1'b1);
		axi_rd(ST_ADDR, rd, resp);
		check(rd, 32'h00000005);
		$display("test reset_defaults done");

		axi_wr(LH_ADDR, 32'h0000ffff, resp);
		check(32'(resp), 32'h0);
		axi_rd(LH_ADDR, rd, resp);
		check(32'(resp), 32'h0);
		check(rd, 32'h00003fff);
		axi_wr(12'h200, 32'h00001234, resp);
		check(32'(resp), 32'h2);
		axi_rd(12'h200, rd, resp);
		check(32'(resp), 32'h2);
		check(rd, 32'h0);
		$display("test register_access done");

		lvl <= 1'b0;
		for (int t = 0; t < 4; t++) begin
			axi_wr(LL_ADDR, {16'h0, 2'(t), 7'd1, 7'd2}, resp);
			axi_rd(LL_ADDR, rd, resp);
			check(rd, {16'h0, 2'(t), 7'd1, 7'd2});
			pair_check(1, 2, tb_len[t]);
		end
		$display("test time_bases done");

		axi_wr(LL_ADDR, {16'h0, 2'b01, 7'd1, 7'd2}, resp);
		axi_wr(LH_ADDR, {18'h0, 7'd3, 7'd1}, resp);
		lvl <= 1'b1;
		pair_check(3, 1, 64);
		axi_wr(LH_ADDR, {18'h0, 7'd0, 7'd5}, resp);
		stat_check(1'b0);
		axi_wr(LH_ADDR, {18'h0, 7'd0, 7'd0}, resp);
		stat_check(1'b0);
		axi_wr(LH_ADDR, {18'h0, 7'd5, 7'd0}, resp);
		stat_check(1'b1);
		$display("test high_level_pair done");
		close_out();
	end
endmodule
`default_nettype wire
